// ---- rtl/psmc_defines.svh ----
// Constants for the power saving mode controller
`ifndef PSMC_DEFINES_SVH
`define PSMC_DEFINES_SVH
// ----------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------
`define PSMC_CLKCTL_OFS 12'h000
`define PSMC_STATUS_OFS 12'h004
`define PSMC_CFG_OFS 12'h008
// ----------------------------------------------------------------
// Clock control register fields
// ----------------------------------------------------------------
`define PSMC_SLOW_EN_BIT 0
`define PSMC_PRESC_LSB 1
`define PSMC_OSC_IRQ_EN_BIT 3
`define PSMC_CLKCTL_RST 4'h0
// ----------------------------------------------------------------
// Mask level forced on entry (interrupts enabled)
// ----------------------------------------------------------------
`define PSMC_MASK_ENABLE_ALL 2'h2
// ----------------------------------------------------------------
// Stabilisation delays in CPU cycles, and the run mode clock divider
// ----------------------------------------------------------------
`define PSMC_DELAY_SHORT_CYC 256
`define PSMC_DELAY_LONG_CYC 4096
`define PSMC_RUN_DIV 2
`endif

// ---- rtl/psmc_pkg.sv ----
// Types for the power saving mode controller
package psmc_pkg;
    typedef enum logic [2:0] {
        PSMC_RUN,
        PSMC_SLOW,
        PSMC_WAIT,
        PSMC_SLOW_WAIT,
        PSMC_ACTIVE_HALT,
        PSMC_HALT,
        PSMC_STABILIZE
    } psmc_mode_t;
    typedef logic [1:0] psmc_presc_t;
endpackage

// ---- rtl/psmc_ctrl.sv ----
// Power saving mode controller: modes, clock divider, gating, oscillator
`timescale 1ns/1ps
`include "psmc_defines.svh"
module psmc_ctrl #(
    parameter int DELAY_SHORT = `PSMC_DELAY_SHORT_CYC,
    parameter int DELAY_LONG = `PSMC_DELAY_LONG_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU core
    input wire logic wait_for_irq_instr,
    input wire logic halt_instr,
    input wire logic irq_enter,
    input wire logic irq_return,
    input wire logic [1:0] irq_level,
    input wire logic [1:0] condition_code_mask,
    output logic mask_force,
    output logic [1:0] mask_force_val,
    output logic cc_push,
    output logic cpu_resume,
    // Interrupt sources
    input wire logic irq_pending,
    input wire logic ext_irq,
    input wire logic timebase_irq,
    input wire logic tli_irq,
    input wire logic spi_irq,
    input wire logic spi_slave_mode,
    input wire logic pwm_irq,
    input wire logic pwm_ext_clock,
    // Options and watchdog
    input wire logic long_delay_option,
    input wire logic watchdog_in_stop_option,
    input wire logic watchdog_enabled,
    output logic watchdog_halt_reset,
    output logic watchdog_freeze,
    // Clock controller
    output logic osc_enable,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic timebase_clk_en,
    output logic [4:0] cpu_clock_div,
    output psmc_pkg::psmc_mode_t mode
);
    import psmc_pkg::*;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic [4:0] div_of(input logic slow, input psmc_presc_t p);
        if (slow) begin
            div_of = 5'h02 << p;
        end else begin
            div_of = 5'(`PSMC_RUN_DIV);
        end
    endfunction

    function automatic logic is_halted(input psmc_mode_t m);
        is_halted = (m == PSMC_HALT) || (m == PSMC_STABILIZE);
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic slow_mode_select_q;
    psmc_presc_t slow_clock_prescale_q;
    logic osc_irq_enable_q;
    psmc_mode_t mode_q;
    psmc_mode_t mode_d;
    logic [12:0] delay_cnt_q;
    logic delay_long_q;
    logic from_reset_q;
    logic wake_irq_q;
    logic mode_entry_q;
    logic halt_wake;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign addr_ok = (paddr == `PSMC_CLKCTL_OFS) || (paddr == `PSMC_STATUS_OFS)
        || (paddr == `PSMC_CFG_OFS);

    // Only reset-capable sources; SPI and PWM need their own clocks
    assign halt_wake = tli_irq || timebase_irq || ext_irq || (spi_irq && spi_slave_mode)
        || (pwm_irq && pwm_ext_clock);

    // ----------------------------------------------------------------
    // Clock control register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            {osc_irq_enable_q, slow_clock_prescale_q, slow_mode_select_q} <= `PSMC_CLKCTL_RST;
        end else if (wr_en && paddr == `PSMC_CLKCTL_OFS) begin
            slow_mode_select_q <= pwdata[`PSMC_SLOW_EN_BIT];
            slow_clock_prescale_q <= pwdata[`PSMC_PRESC_LSB +: 2];
            osc_irq_enable_q <= pwdata[`PSMC_OSC_IRQ_EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // APB read path and answer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // No wait state: answer registered in setup, valid in access
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (rd_en) begin
                case (paddr)
                    `PSMC_CLKCTL_OFS: prdata <= {28'h0, osc_irq_enable_q,
                        slow_clock_prescale_q, slow_mode_select_q};
                    `PSMC_STATUS_OFS: prdata <= {19'h0, delay_cnt_q};
                    `PSMC_CFG_OFS: prdata <= {24'h0, 2'h0, long_delay_option,
                        watchdog_in_stop_option, 1'b0, mode_q};
                    default: prdata <= 32'h0000_0000;
                endcase
            end else if (!psel) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Mode sequencing
    // ----------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            PSMC_RUN, PSMC_SLOW: begin
                if (wait_for_irq_instr) begin
                    mode_d = slow_mode_select_q ? PSMC_SLOW_WAIT : PSMC_WAIT;
                end else if (halt_instr) begin
                    if (irq_pending) begin
                        mode_d = mode_q;
                    end else if (osc_irq_enable_q) begin
                        mode_d = PSMC_ACTIVE_HALT;
                    end else begin
                        mode_d = PSMC_HALT;
                    end
                end else begin
                    mode_d = slow_mode_select_q ? PSMC_SLOW : PSMC_RUN;
                end
            end
            PSMC_WAIT, PSMC_SLOW_WAIT: begin
                if (irq_pending) begin
                    mode_d = slow_mode_select_q ? PSMC_SLOW : PSMC_RUN;
                end
            end
            PSMC_ACTIVE_HALT: begin
                if (ext_irq || timebase_irq || tli_irq) begin
                    mode_d = PSMC_RUN;
                end
            end
            PSMC_HALT: begin
                if (halt_wake) begin
                    mode_d = PSMC_STABILIZE;
                end
            end
            PSMC_STABILIZE: begin
                if (delay_cnt_q == 13'h0001) begin
                    mode_d = PSMC_RUN;
                end
            end
            default: mode_d = PSMC_RUN;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode_q <= PSMC_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Delay choice caught after reset release, held static
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            from_reset_q <= 1'b1;
            delay_long_q <= 1'b0;
        end else begin
            from_reset_q <= 1'b0;
            if (from_reset_q) begin
                delay_long_q <= long_delay_option;
            end
        end
    end

    // ----------------------------------------------------------------
    // Wake-up stabilisation counter, runs on CPU cycles
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            delay_cnt_q <= 13'h0000;
        end else if (mode_q == PSMC_HALT && halt_wake) begin
            delay_cnt_q <= delay_long_q ? 13'(DELAY_LONG) : 13'(DELAY_SHORT);
        end else if (mode_q == PSMC_STABILIZE && delay_cnt_q != 13'h0000) begin
            delay_cnt_q <= delay_cnt_q - 13'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Mask forcing and interrupt entry
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode_entry_q <= 1'b0;
            mask_force <= 1'b0;
            mask_force_val <= 2'h3;
            cc_push <= 1'b0;
        end else begin
            mode_entry_q <= (mode_q == PSMC_RUN || mode_q == PSMC_SLOW)
                && (wait_for_irq_instr || halt_instr);
            cc_push <= irq_enter;
            if ((mode_q == PSMC_RUN || mode_q == PSMC_SLOW)
                && (wait_for_irq_instr || halt_instr)) begin
                mask_force <= 1'b1;
                mask_force_val <= `PSMC_MASK_ENABLE_ALL;
            end else if (irq_enter) begin
                mask_force <= 1'b1;
                mask_force_val <= irq_level;
            end else if (irq_return) begin
                mask_force <= 1'b1;
                mask_force_val <= condition_code_mask;
            end else begin
                mask_force <= 1'b0;
            end
        end
    end

    // Resume pulse once CPU clock returns from any stop mode
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wake_irq_q <= 1'b0;
            cpu_resume <= 1'b0;
        end else begin
            wake_irq_q <= (mode_q != PSMC_RUN && mode_q != PSMC_SLOW)
                && (mode_d == PSMC_RUN || mode_d == PSMC_SLOW);
            cpu_resume <= wake_irq_q;
        end
    end

    // ----------------------------------------------------------------
    // Clock gating, oscillator and watchdog
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            osc_enable <= 1'b1;
            cpu_clk_en <= 1'b1;
            periph_clk_en <= 1'b1;
            timebase_clk_en <= 1'b1;
            cpu_clock_div <= 5'(`PSMC_RUN_DIV);
        end else begin
            osc_enable <= (mode_d != PSMC_HALT);
            cpu_clk_en <= (mode_d == PSMC_RUN) || (mode_d == PSMC_SLOW);
            periph_clk_en <= (mode_d == PSMC_RUN) || (mode_d == PSMC_SLOW)
                || (mode_d == PSMC_WAIT) || (mode_d == PSMC_SLOW_WAIT);
            timebase_clk_en <= !is_halted(mode_d);
            cpu_clock_div <= div_of(slow_mode_select_q, slow_clock_prescale_q);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            watchdog_halt_reset <= 1'b0;
            watchdog_freeze <= 1'b0;
        end else begin
            // Entering halt with watchdog running and option clear resets
            watchdog_halt_reset <= (mode_q == PSMC_RUN || mode_q == PSMC_SLOW) && halt_instr
                && !wait_for_irq_instr && !irq_pending && !osc_irq_enable_q
                && watchdog_enabled && !watchdog_in_stop_option;
            watchdog_freeze <= (mode_d == PSMC_ACTIVE_HALT);
        end
    end

    assign mode = mode_q;
endmodule

// ---- tb/psmc_core_model.sv ----
// Core-side model issuing instruction and interrupt entry pulses
`timescale 1ns/1ps
module psmc_core_model (
    // Clock, reset and requests
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [2:0] go_q,
    input wire logic cpu_clk_en,
    // Core pulses
    output logic wait_for_irq_instr,
    output logic halt_instr,
    output logic irq_enter
);
    // A stopped core executes nothing, so requests then are lost
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            {wait_for_irq_instr, halt_instr, irq_enter} <= 3'h0;
        end else begin
            {irq_enter, halt_instr, wait_for_irq_instr} <= go_q & {3{cpu_clk_en}};
        end
    end
endmodule

// ---- tb/psmc_ctrl_props.sv ----
// Concurrent checks on the power saving mode controller ports
`timescale 1ns/1ps
module psmc_ctrl_props (
    // Clock, reset and core
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wait_for_irq_instr,
    input wire logic halt_instr,
    input wire logic irq_enter,
    input wire logic irq_pending,
    // Controller outputs
    input wire logic mask_force,
    input wire logic [1:0] mask_force_val,
    input wire logic cc_push,
    input wire logic osc_enable,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic timebase_clk_en,
    input wire logic [4:0] cpu_clock_div,
    input wire psmc_pkg::psmc_mode_t mode
);
    import psmc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Enables are registered, so gating is judged once the mode has settled
    run_div_a: assert property (mode == PSMC_RUN && $stable(mode) |-> cpu_clock_div == 5'h02)
        else $error("run divisor wrong");
    slow_div_a: assert property (mode == PSMC_SLOW && $stable(mode) |-> cpu_clk_en &&
        periph_clk_en && cpu_clock_div inside {5'h02, 5'h04, 5'h08, 5'h10})
        else $error("slow clocking wrong");
    wait_gate_a: assert property ((mode == PSMC_WAIT || mode == PSMC_SLOW_WAIT)
        && $stable(mode) |-> !cpu_clk_en && periph_clk_en) else $error("wait gating wrong");
    wait_mask_a: assert property (wait_for_irq_instr && mode == PSMC_RUN && !irq_pending
        |-> ##[1:2] (mask_force && mask_force_val == 2'h2)) else $error("wait mask wrong");
    push_a: assert property (irq_enter |=> cc_push)
        else $error("no push after entry");
    halt_pick_a: assert property (halt_instr && mode == PSMC_RUN && !irq_pending
        |=> mode inside {PSMC_HALT, PSMC_ACTIVE_HALT}) else $error("halt not entered");
    ahalt_clock_a: assert property (mode == PSMC_ACTIVE_HALT && $stable(mode) |->
        osc_enable && timebase_clk_en && !periph_clk_en && !cpu_clk_en)
        else $error("active halt clocks wrong");
    halt_off_a: assert property (mode == PSMC_HALT && $stable(mode) |->
        !osc_enable && !cpu_clk_en && !periph_clk_en) else $error("halt clocks wrong");
    cover property (mode == PSMC_SLOW_WAIT);
    cover property (mode == PSMC_ACTIVE_HALT ##1 mode == PSMC_RUN);
    cover property (mode == PSMC_STABILIZE ##1 mode == PSMC_RUN);
endmodule
bind psmc_ctrl psmc_ctrl_props props_u (.mclk, .rst_n, .wait_for_irq_instr, .halt_instr,
    .irq_enter, .irq_pending, .mask_force, .mask_force_val, .cc_push, .osc_enable,
    .cpu_clk_en, .periph_clk_en, .timebase_clk_en, .cpu_clock_div, .mode);

// ---- tb/psmc_ctrl_bench.sv ----
// Self-checking bench for the power saving mode controller
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin checks++; if ((ac) !== (ex)) begin mismatches++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, ac); end end
module psmc_ctrl_bench;
    import psmc_pkg::*;
    localparam int DS = 4;
    localparam int DL = 16;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err, push_seen, wdg_seen;
    logic res_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic wait_for_irq_instr, halt_instr, irq_enter, irq_return, mask_force, cc_push, cpu_resume;
    logic [1:0] irq_level, condition_code_mask, mask_force_val, last_mask;
    logic irq_pending, ext_irq, timebase_irq, tli_irq, spi_irq, spi_slave_mode, pwm_irq;
    logic pwm_ext_clock, long_delay_option, watchdog_in_stop_option, watchdog_enabled;
    logic watchdog_halt_reset, watchdog_freeze, osc_enable, cpu_clk_en, periph_clk_en;
    logic timebase_clk_en;
    logic [4:0] cpu_clock_div;
    logic [2:0] go_q;
    psmc_mode_t mode;
    int mismatches = 0;
    int checks = 0;
    int n;
    psmc_ctrl #(.DELAY_SHORT(DS), .DELAY_LONG(DL)) dut_u (.mclk, .rst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wait_for_irq_instr,
        .halt_instr, .irq_enter, .irq_return, .irq_level, .condition_code_mask, .mask_force,
        .mask_force_val, .cc_push, .cpu_resume, .irq_pending, .ext_irq, .timebase_irq,
        .tli_irq, .spi_irq, .spi_slave_mode, .pwm_irq, .pwm_ext_clock, .long_delay_option,
        .watchdog_in_stop_option, .watchdog_enabled, .watchdog_halt_reset, .watchdog_freeze,
        .osc_enable, .cpu_clk_en, .periph_clk_en, .timebase_clk_en, .cpu_clock_div, .mode);
    psmc_core_model core_u (.mclk, .rst_n, .go_q, .cpu_clk_en, .wait_for_irq_instr,
        .halt_instr, .irq_enter);
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Pulses are short, so they are caught here and judged later
    always @(posedge mclk) begin
        if (cc_push) push_seen <= 1'b1;
        if (mask_force) last_mask <= mask_force_val;
        if (watchdog_halt_reset) wdg_seen <= 1'b1;
        if (cpu_resume) res_seen <= 1'b1;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        // Only the watchdog process ends a wait for the answer
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic go(input int k);
        go_q <= 3'(1 << k);
        @(posedge mclk);
        go_q <= 3'h0;
    endtask
    task automatic wmode(input psmc_mode_t m);
        for (int i = 0; i < 60; i++) begin
            @(posedge mclk);
            if (mode === m) break;
        end
    endtask
    task automatic t_reset;
        `CHK("run", 11'h017, {mode, cpu_clock_div, osc_enable, cpu_clk_en, periph_clk_en})
        apb(1'b0, 12'h000, 32'h0);
        `CHK("ctl", 32'h0, rd)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK("hole", 1'b1, err)
    endtask
    task automatic t_slow;
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, 12'h000, 32'(2 * p + 1));
            repeat (3) @(posedge mclk);
            `CHK("div", {PSMC_SLOW, 5'(2 << p)}, {mode, cpu_clock_div})
        end
        go(0);
        wmode(PSMC_SLOW_WAIT);
        @(posedge mclk);
        `CHK("sw", {PSMC_SLOW_WAIT, 6'h10}, {mode, cpu_clk_en, cpu_clock_div})
        irq_pending <= 1'b1;
        wmode(PSMC_SLOW);
        irq_pending <= 1'b0;
        apb(1'b1, 12'h000, 32'h0);
    endtask
    task automatic t_wait;
        go(0);
        wmode(PSMC_WAIT);
        repeat (2) @(posedge mclk);
        `CHK("wait", 4'h6, {cpu_clk_en, periph_clk_en, last_mask})
        irq_pending <= 1'b1;
        wmode(PSMC_RUN);
        `CHK("wake", PSMC_RUN, mode)
        {irq_pending, push_seen, irq_level} <= 4'h3;
        go(2);
        repeat (3) @(posedge mclk);
        `CHK("push", 3'h7, {push_seen, last_mask})
        {condition_code_mask, irq_return} <= 3'h3;
        @(posedge mclk);
        irq_return <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK("pop", 2'h1, last_mask)
    endtask
    task automatic t_ahalt;
        apb(1'b1, 12'h000, 32'h8);
        wdg_seen <= 1'b0;
        for (int s = 0; s < 3; s++) begin
            go(1);
            wmode(PSMC_ACTIVE_HALT);
            @(posedge mclk);
            `CHK("ah", 4'hc, {osc_enable, timebase_clk_en, periph_clk_en, cpu_clk_en})
            `CHK("freeze", 1'b1, watchdog_freeze)
            {tli_irq, timebase_irq, ext_irq} <= 3'(1 << s);
            repeat (2) @(posedge mclk);
            `CHK("ahexit", PSMC_RUN, mode)
            {tli_irq, timebase_irq, ext_irq} <= 3'h0;
            repeat (2) @(posedge mclk);
        end
        `CHK("wdg", 1'b0, wdg_seen)
        irq_pending <= 1'b1;
        go(1);
        repeat (6) @(posedge mclk);
        `CHK("pend", PSMC_RUN, mode)
        irq_pending <= 1'b0;
    endtask
    task automatic t_halt(input logic opt);
        @(posedge mclk);
        {rst_n, long_delay_option, watchdog_in_stop_option} <= {1'b0, opt, opt};
        repeat (4) @(posedge mclk);
        {rst_n, wdg_seen, res_seen} <= 3'b100;
        go(1);
        wmode(PSMC_HALT);
        spi_irq <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHK("halt", {4'h8, !opt}, {mode == PSMC_HALT, osc_enable, cpu_clk_en, periph_clk_en, wdg_seen})
        {spi_irq, ext_irq} <= 2'b01;
        wmode(PSMC_STABILIZE);
        ext_irq <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (mode === PSMC_STABILIZE && n < 99);
        `CHK("stab", opt ? DL : DS, n)
        repeat (2) @(posedge mclk);
        `CHK("resume", 1'b1, res_seen)
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, go_q, rst_n, irq_return, irq_level} = '0;
        {condition_code_mask, irq_pending, ext_irq, timebase_irq, tli_irq, spi_irq} = '0;
        {spi_slave_mode, pwm_irq, pwm_ext_clock, long_delay_option, watchdog_in_stop_option} = '0;
        {push_seen, wdg_seen, last_mask, watchdog_enabled} = 5'h01;
        res_seen = 1'b0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_slow();
        t_wait();
        t_ahalt();
        t_halt(1'b0);
        t_halt(1'b1);
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        end_of_test();
    end
endmodule
